// file: hdl/adcpm_regs.svh
// register map, field positions, reset values and timing for the
// converter pin-mode decoder; included by the decoder top and the testbench
`ifndef ADCPM_REGS_SVH
`define ADCPM_REGS_SVH

`define ADCPM_ADDR_W 4
`define ADCPM_OFS_CTRL 4'h0
`define ADCPM_OFS_STATUS 4'h4

`define ADCPM_CTRL_RESET 6'h00
`define ADCPM_CTRL_W 6
`define ADCPM_CTRL_PAIR 0
`define ADCPM_CTRL_BYTE 1
`define ADCPM_CTRL_CHAN 2
`define ADCPM_CTRL_LOWPWR 3
`define ADCPM_CTRL_SERIAL 4
`define ADCPM_CTRL_RDC 5

`define ADCPM_ST_SERIAL 0
`define ADCPM_ST_SLAVE 1
`define ADCPM_ST_DIV_LO 2
`define ADCPM_ST_DIV_HI 3
`define ADCPM_ST_EMPTY 4
`define ADCPM_ST_FULL 5
`define ADCPM_ST_BUSY 6

`define ADCPM_RESP_OKAY 2'h0
`define ADCPM_RESP_SLVERR 2'h2

`define ADCPM_BIT_DIV0 2
`define ADCPM_BIT_DIV1 3
`define ADCPM_BIT_CLKSRC 4
`define ADCPM_BIT_CHAIN 7
`define ADCPM_BIT_SOUT 8
`define ADCPM_OE_PAR 16'hFFFF
`define ADCPM_OE_SER 16'h0100

`define ADCPM_WORD_BITS 32
`define ADCPM_FIFO_DEPTH 32
`define ADCPM_CLK_NS 5
`define ADCPM_SCLK_P0_NS 40
`define ADCPM_SCLK_P1_NS 70
`define ADCPM_SCLK_P2_NS 140
`define ADCPM_SCLK_P3_NS 280

`endif

// file: hdl/adcpm_pkg.sv
// types shared by the pin-mode decoder files
// assumes nothing beyond a SystemVerilog compiler
package adcpm_pkg;
    typedef enum logic [1:0] {
        ADCPM_IDLE = 2'b00,
        ADCPM_WAIT = 2'b01,
        ADCPM_SHIFT = 2'b11
    } adcpm_ser_state_t;
endpackage

// file: hdl/adcpm_fifo.sv
// result buffer: parameterised fifo with registered read data
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module adcpm_fifo
    import adcpm_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty,
    output logic full
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic push;
    logic fetch;
    logic mem_empty;

    assign mem_empty = (wptr == rptr);
    assign full = (wptr[AW-1:0] == rptr[AW-1:0]) && (wptr[AW] != rptr[AW]);
    assign empty = mem_empty && !out_valid;
    assign in_ready = !full;
    assign push = in_valid && in_ready;
    // head register refills as soon as it is free or being drained
    assign fetch = !mem_empty && (!out_valid || out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wptr <= '0;
        end else if (push) begin
            wptr <= wptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rptr <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (fetch) begin
            rptr <= rptr + 1'b1;
            out_valid <= 1'b1;
            out_data <= mem[rptr[AW-1:0]];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// file: hdl/adcpm_top.sv
// converter pin-mode decoder: axi4-lite control, result fifo,
// parallel bus and serial port sharing the data pins
// assumes results arrive from the conversion core on SYS_CLK and
// that all pins are synchronous to SYS_CLK
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "adcpm_regs.svh"

// Summary of operation
// - pair select picks first or second inputs
// - byte order select swaps parallel bytes
// - parallel shows B when low, A high
// - serial shifts selected channel first, other next
// - low-power select enters reduced power mode
// - port type picks parallel or serial port
// - lowest two data outputs float in serial
// - bits 2,3 become divider inputs in serial
// - divider used only in master read-after-convert
// - bit 4 becomes clock source input serially
// - clock source low master, high slave
// - divider gives 40,70,140,280 ns periods
// - 32-bit shift register, most significant first
// - read during convert high, else after
module adcpm_top
    import adcpm_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [`ADCPM_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [`ADCPM_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [15:0] CONV_A,
    input wire logic [15:0] CONV_B,
    input wire logic CONV_VALID,
    output logic CONV_READY,
    input wire logic CONV_BUSY,
    output logic MUX_SELECT,
    output logic LOW_POWER,
    input wire logic PAR_RD,
    input wire logic [15:0] D_IN,
    output logic [15:0] D_OUT,
    output logic [15:0] D_OE,
    input wire logic SCLK_IN,
    output logic SCLK_OUT,
    output logic SCLK_OE
);
    localparam logic [5:0] HALF0 =
        6'((`ADCPM_SCLK_P0_NS / `ADCPM_CLK_NS) / 2);
    localparam logic [5:0] HALF1 =
        6'((`ADCPM_SCLK_P1_NS / `ADCPM_CLK_NS) / 2);
    localparam logic [5:0] HALF2 =
        6'((`ADCPM_SCLK_P2_NS / `ADCPM_CLK_NS) / 2);
    localparam logic [5:0] HALF3 =
        6'((`ADCPM_SCLK_P3_NS / `ADCPM_CLK_NS) / 2);
    localparam logic [5:0] WORD_BITS = 6'(`ADCPM_WORD_BITS);

    logic [`ADCPM_CTRL_W-1:0] ctrl;
    logic serial_mode;
    logic slave_mode;
    logic master_rac;
    logic rdc;
    logic [1:0] divider;
    logic [5:0] half_per;
    logic wr_take;
    logic rd_take;
    logic [31:0] status;

    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic fifo_empty;
    logic fifo_full;

    logic [15:0] par_word;
    adcpm_ser_state_t state;
    adcpm_ser_state_t next_state;
    logic [31:0] shreg;
    logic [5:0] bit_cnt;
    logic [5:0] clk_cnt;
    logic sclk;
    logic sclk_in_q;
    logic shift_tick;
    logic load;

    // ---------------- mode decode ----------------
    assign serial_mode = ctrl[`ADCPM_CTRL_SERIAL];
    assign rdc = ctrl[`ADCPM_CTRL_RDC];
    // in serial mode the shared pins other than serial output bit 8 are inputs carrying the options
    assign slave_mode = serial_mode && D_IN[`ADCPM_BIT_CLKSRC];
    assign divider = {D_IN[`ADCPM_BIT_DIV1], D_IN[`ADCPM_BIT_DIV0]};
    assign master_rac = serial_mode && !slave_mode && !rdc;
    assign MUX_SELECT = ctrl[`ADCPM_CTRL_PAIR];
    assign LOW_POWER = ctrl[`ADCPM_CTRL_LOWPWR];

    always_comb begin
        half_per = HALF0;
        if (master_rac) begin
            case (divider)
                2'b01: half_per = HALF1;
                2'b10: half_per = HALF2;
                2'b11: half_per = HALF3;
                default: half_per = HALF0;
            endcase
        end
    end

    // ---------------- axi4-lite slave ----------------
    // write waits for both channels so the response follows both
    assign wr_take = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
    assign S_AXI_AWREADY = wr_take;
    assign S_AXI_WREADY = wr_take;
    assign rd_take = S_AXI_ARVALID && !S_AXI_RVALID;
    assign S_AXI_ARREADY = rd_take;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl <= `ADCPM_CTRL_RESET;
        end else if (wr_take && S_AXI_AWADDR == `ADCPM_OFS_CTRL
                     && S_AXI_WSTRB[0]) begin
            ctrl <= S_AXI_WDATA[`ADCPM_CTRL_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `ADCPM_RESP_OKAY;
        end else if (wr_take) begin
            S_AXI_BVALID <= 1'b1;
            if (S_AXI_AWADDR == `ADCPM_OFS_CTRL
                || S_AXI_AWADDR == `ADCPM_OFS_STATUS) begin
                S_AXI_BRESP <= `ADCPM_RESP_OKAY;
            end else begin
                S_AXI_BRESP <= `ADCPM_RESP_SLVERR;
            end
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[`ADCPM_ST_SERIAL] = serial_mode;
        status[`ADCPM_ST_SLAVE] = slave_mode;
        status[`ADCPM_ST_DIV_LO] = master_rac && divider[0];
        status[`ADCPM_ST_DIV_HI] = master_rac && divider[1];
        status[`ADCPM_ST_EMPTY] = fifo_empty;
        status[`ADCPM_ST_FULL] = fifo_full;
        status[`ADCPM_ST_BUSY] = (state != ADCPM_IDLE);
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `ADCPM_RESP_OKAY;
        end else if (rd_take) begin
            S_AXI_RVALID <= 1'b1;
            if (S_AXI_ARADDR == `ADCPM_OFS_CTRL) begin
                S_AXI_RDATA <= {26'h0, ctrl};
                S_AXI_RRESP <= `ADCPM_RESP_OKAY;
            end else if (S_AXI_ARADDR == `ADCPM_OFS_STATUS) begin
                S_AXI_RDATA <= status;
                S_AXI_RRESP <= `ADCPM_RESP_OKAY;
            end else begin
                S_AXI_RDATA <= 32'h0000_0000;
                S_AXI_RRESP <= `ADCPM_RESP_SLVERR;
            end
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ---------------- result buffer ----------------
    adcpm_fifo #(
        .WIDTH(`ADCPM_WORD_BITS),
        .DEPTH(`ADCPM_FIFO_DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_valid(CONV_VALID),
        .in_ready(CONV_READY),
        .in_data({CONV_A, CONV_B}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    assign load = serial_mode && state == ADCPM_IDLE && fifo_out_valid;
    // parallel words leave only on the host read strobe
    assign fifo_out_ready = serial_mode ? load : PAR_RD;

    // ---------------- parallel port ----------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            par_word <= 16'h0000;
        end else if (!serial_mode && PAR_RD && fifo_out_valid) begin
            par_word <= ctrl[`ADCPM_CTRL_CHAN] ? fifo_out_data[31:16]
                                               : fifo_out_data[15:0];
        end
    end

    // ---------------- serial port ----------------
    always_comb begin
        next_state = state;
        case (state)
            ADCPM_IDLE: begin
                if (load) begin
                    next_state = (master_rac && CONV_BUSY) ? ADCPM_WAIT
                                                           : ADCPM_SHIFT;
                end
            end
            ADCPM_WAIT: begin
                if (!CONV_BUSY) begin
                    next_state = ADCPM_SHIFT;
                end
            end
            ADCPM_SHIFT: begin
                if (shift_tick && bit_cnt == WORD_BITS - 6'h01) begin
                    next_state = ADCPM_IDLE;
                end
            end
            default: next_state = ADCPM_IDLE;
        endcase
        if (!serial_mode) begin
            next_state = ADCPM_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state <= ADCPM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sclk_in_q <= 1'b0;
        end else begin
            sclk_in_q <= SCLK_IN;
        end
    end

    // master clock from a half-period counter; data moves on its fall
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            clk_cnt <= 6'h00;
            sclk <= 1'b0;
        end else if (state != ADCPM_SHIFT || slave_mode) begin
            clk_cnt <= 6'h00;
            sclk <= 1'b0;
        end else if (clk_cnt == half_per - 6'h01) begin
            clk_cnt <= 6'h00;
            sclk <= !sclk;
        end else begin
            clk_cnt <= clk_cnt + 6'h01;
        end
    end

    always_comb begin
        if (slave_mode) begin
            shift_tick = state == ADCPM_SHIFT && SCLK_IN && !sclk_in_q;
        end else begin
            shift_tick = state == ADCPM_SHIFT && sclk
                         && clk_cnt == half_per - 6'h01;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            shreg <= 32'h0000_0000;
            bit_cnt <= 6'h00;
        end else if (load) begin
            shreg <= ctrl[`ADCPM_CTRL_CHAN] ? fifo_out_data
                     : {fifo_out_data[15:0], fifo_out_data[31:16]};
            bit_cnt <= 6'h00;
        end else if (shift_tick) begin
            // chain input refills from the bottom in slave mode
            shreg <= {shreg[30:0], slave_mode && D_IN[`ADCPM_BIT_CHAIN]};
            bit_cnt <= bit_cnt + 6'h01;
        end
    end

    assign SCLK_OUT = sclk;
    assign SCLK_OE = serial_mode && !slave_mode;

    always_comb begin
        if (serial_mode) begin
            D_OE = `ADCPM_OE_SER;
            D_OUT = 16'h0000;
            D_OUT[`ADCPM_BIT_SOUT] = shreg[31];
        end else begin
            D_OE = `ADCPM_OE_PAR;
            D_OUT = ctrl[`ADCPM_CTRL_BYTE] ? {par_word[7:0], par_word[15:8]}
                                           : par_word;
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // high-time count, so the slow clock needs no long repetition
    logic [5:0] hi_cnt;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || !sclk) begin
            hi_cnt <= 6'h00;
        end else begin
            hi_cnt <= hi_cnt + 6'h01;
        end
    end

    sequence ser_load_s;
        load && ctrl[`ADCPM_CTRL_CHAN];
    endsequence
    sequence ser_fall_s;
        state == ADCPM_SHIFT && !slave_mode && shift_tick;
    endsequence

    pair_mux_a: assert property (MUX_SELECT == ctrl[`ADCPM_CTRL_PAIR])
        else $error("mux select differs from control");
    byte_swap_a: assert property (!serial_mode && ctrl[`ADCPM_CTRL_BYTE]
        |-> D_OUT[7:0] == par_word[15:8])
        else $error("byte order not swapped");
    par_channel_a: assert property (!serial_mode && PAR_RD && fifo_out_valid
        && !ctrl[`ADCPM_CTRL_CHAN] |=> par_word == $past(fifo_out_data[15:0]))
        else $error("parallel word not channel b");
    ser_order_a: assert property (ser_load_s
        |=> shreg == $past(fifo_out_data))
        else $error("serial order wrong for channel a first");
    low_power_a: assert property (LOW_POWER == ctrl[`ADCPM_CTRL_LOWPWR])
        else $error("low power output wrong");
    low_hiz_a: assert property (serial_mode |-> D_OE[1:0] == 2'b00)
        else $error("low data bits driven in serial");
    par_drive_a: assert property (!serial_mode |-> D_OE == 16'hFFFF)
        else $error("parallel bus not fully driven");
    div_ignore_a: assert property (!master_rac |-> half_per == HALF0)
        else $error("divider used outside read after convert");
    sclk_period_a: assert property (master_rac && divider == 2'b11
        && $fell(sclk) |-> hi_cnt == HALF3)
        else $error("slowest serial clock high time wrong");
    msb_first_a: assert property (ser_fall_s
        |=> D_OUT[`ADCPM_BIT_SOUT] == $past(shreg[30]))
        else $error("serial output not msb first");
    wait_conv_a: assert property (state == ADCPM_WAIT && CONV_BUSY
        |=> state == ADCPM_WAIT && bit_cnt == 6'h00)
        else $error("shifted before conversion completed");
    master_clk_a: assert property (serial_mode && !D_IN[`ADCPM_BIT_CLKSRC]
        |-> SCLK_OE)
        else $error("master does not drive serial clock");
    bresp_time_a: assert property (wr_take |=> S_AXI_BVALID)
        else $error("write response late");
endmodule

// file: verification/adcpm_host.sv
// host controller model: follows the device serial clock as master or
// supplies it as slave, and collects one 32-bit result word msb first
// assumes the device pins are synchronous to clk
`timescale 1ns/1ps
module adcpm_host (
    input wire logic clk,
    input wire logic slave,
    input wire logic go,
    input wire logic clr,
    input wire logic [7:0] half,
    input wire logic sclk,
    input wire logic sdata,
    output logic sclk_drv,
    output logic [31:0] word,
    output logic [7:0] bits,
    output logic [15:0] period
);
    logic prev = 1'b0;
    logic [15:0] cnt = 16'h0;
    logic [7:0] ph = 8'h0;

    initial begin
        sclk_drv = 1'b0;
        word = 32'h0;
        bits = 8'h0;
        period = 16'h0;
    end

    always @(posedge clk) begin
        prev <= sclk;
        cnt <= cnt + 16'h1;
        if (clr) begin
            bits <= 8'h0;
        end else if (!slave && sclk && !prev) begin
            // sampled mid-bit; the device moves data on the fall
            word <= {word[30:0], sdata};
            bits <= bits + 8'h1;
            period <= cnt + 16'h1;
            cnt <= 16'h0;
        end
        // slave clock runs only inside a frame, low otherwise
        if (slave && go && !clr && bits < 8'h20) begin
            ph <= (ph == half) ? 8'h0 : ph + 8'h1;
            if (ph == half) begin
                sclk_drv <= !sclk_drv;
                if (!sclk_drv) begin
                    word <= {word[30:0], sdata};
                    bits <= bits + 8'h1;
                end
            end
        end else begin
            sclk_drv <= 1'b0;
            ph <= 8'h0;
        end
    end
endmodule

// file: verification/testbench.sv
// self-checking bench for the pin-mode decoder: registers over
// axi4-lite, parallel and serial readout, buffer fill and drain
// assumes the host model adcpm_host beside the design
`timescale 1ns/1ps
`include "adcpm_regs.svh"
module testbench;
    typedef struct packed {
        logic wr;
        logic [3:0] a;
        logic [31:0] d;
        logic [1:0] resp;
        logic [31:0] rd;
        logic [1:0] ml;
    } adcpm_row_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] div;
        logic [15:0] ns;
        logic [1:0] eff;
    } adcpm_ser_t;
    localparam logic [3:0] RC = `ADCPM_OFS_CTRL;
    localparam logic [3:0] RS = `ADCPM_OFS_STATUS;
    localparam adcpm_row_t ROWS [9] = '{
        '{1'b1, RC, 32'h09, 2'h0, 32'h0, 2'h3},
        '{1'b0, RC, 32'h0, 2'h0, 32'h09, 2'h3},
        '{1'b1, RC, 32'h08, 2'h0, 32'h0, 2'h1},
        '{1'b1, RS, 32'hFF, 2'h0, 32'h0, 2'h1},
        '{1'b0, RS, 32'h0, 2'h0, 32'h10, 2'h1},
        '{1'b1, 4'h8, 32'h1, 2'h2, 32'h0, 2'h1},
        '{1'b0, 4'hC, 32'h0, 2'h2, 32'h0, 2'h1},
        '{1'b1, RC, 32'h01, 2'h0, 32'h0, 2'h2},
        '{1'b1, RC, 32'h00, 2'h0, 32'h0, 2'h0}};
    localparam adcpm_ser_t SER [5] = '{
        '{8'h10, 2'd0, `ADCPM_SCLK_P0_NS, 2'd0},
        '{8'h14, 2'd1, `ADCPM_SCLK_P1_NS, 2'd1},
        '{8'h10, 2'd2, `ADCPM_SCLK_P2_NS, 2'd2},
        '{8'h14, 2'd3, `ADCPM_SCLK_P3_NS, 2'd3},
        '{8'h30, 2'd3, `ADCPM_SCLK_P0_NS, 2'd0}};
    logic clk = 1'b0, rst_n = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 32'h0, rdata, word;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [15:0] ca = 16'h0, cb = 16'h0, pins = 16'h0, d_out, d_oe, d_in;
    logic cvalid = 0, cready, cbusy = 0, mux, lowp, par_rd = 0;
    logic sclk_w, sclk_drv, sclk_out, sclk_oe, go = 0, clr = 0;
    logic [7:0] bits, half = 8'h2;
    logic [15:0] period;
    int n_errors = 0, n_compared = 0;

    // each pin carries whichever side enables it
    assign d_in = (d_oe & d_out) | (~d_oe & pins);
    assign sclk_w = sclk_oe ? sclk_out : sclk_drv;
    always #2.5 clk = ~clk;

    adcpm_top i_adcpm_top (.SYS_CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CONV_A(ca),
        .CONV_B(cb), .CONV_VALID(cvalid), .CONV_READY(cready),
        .CONV_BUSY(cbusy), .MUX_SELECT(mux), .LOW_POWER(lowp),
        .PAR_RD(par_rd), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe),
        .SCLK_IN(sclk_w), .SCLK_OUT(sclk_out), .SCLK_OE(sclk_oe));

    adcpm_host i_adcpm_host (.clk(clk), .slave(pins[4]), .go(go),
        .clr(clr), .half(half), .sclk(sclk_w), .sdata(d_out[8]),
        .sclk_drv(sclk_drv), .word(word), .bits(bits), .period(period));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta | (awready === 1'b1);
            tw = tw | (wready === 1'b1);
            @(posedge clk);
            awvalid <= !ta;
            wvalid <= !tw;
        end
        @(negedge clk);
        while (bvalid !== 1'b1)
            @(negedge clk);
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge clk);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axr(input logic [3:0] a, output logic [31:0] d,
            output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge clk);
        while (arready !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        arvalid <= 1'b0;
        @(negedge clk);
        while (rvalid !== 1'b1)
            @(negedge clk);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic push(input logic [15:0] a, input logic [15:0] b);
        ca <= a;
        cb <= b;
        cvalid <= 1'b1;
        @(negedge clk);
        while (cready !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        cvalid <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pop;
        par_rd <= 1'b1;
        @(posedge clk);
        par_rd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic load(input logic [15:0] a, input logic [15:0] b);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        push(a, b);
    endtask

    task automatic wait32;
        while (bits !== 8'h20)
            @(posedge clk);
        // the last bit still has to leave before any pin may change
        repeat (64) @(posedge clk);
    endtask

    initial begin
        #200us;
        n_errors++;
        conclude();
    end

    initial begin
        logic [31:0] rd;
        logic [1:0] rr;
        logic [15:0] a, b;
        int k;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({d_oe, d_out}, 32'hFFFF0000);
        chk({29'h0, sclk_out, bvalid, rvalid}, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            if (ROWS[i].wr)
                axw(ROWS[i].a, ROWS[i].d, ROWS[i].resp);
            else begin
                axr(ROWS[i].a, rd, rr);
                chk(rd, ROWS[i].rd);
                chk({30'h0, rr}, {30'h0, ROWS[i].resp});
            end
            chk({30'h0, mux, lowp}, {30'h0, ROWS[i].ml});
        end
        $display("register test done");
        push(16'h1234, 16'hABCD);
        push(16'h5678, 16'h9EF0);
        repeat (4) @(posedge clk);
        pop();
        chk({d_oe, d_out}, 32'hFFFFABCD);
        axw(RC, 32'h2, 2'h0);
        chk(32'(d_out), 32'hCDAB);
        axw(RC, 32'h4, 2'h0);
        pop();
        chk(32'(d_out), 32'h5678);
        axw(RC, 32'h6, 2'h0);
        chk(32'(d_out), 32'h7856);
        axw(RC, 32'h0, 2'h0);
        $display("parallel test done");
        k = 0;
        repeat (3) @(posedge clk);
        while (cready === 1'b1 && k < 40) begin
            push(16'(k), 16'(k + 100));
            k++;
            repeat (2) @(posedge clk);
        end
        chk(32'(k), 32'(`ADCPM_FIFO_DEPTH + 1));
        axr(RS, rd, rr);
        chk(rd & 32'h30, 32'h20);
        for (int j = 0; j < k; j++) begin
            pop();
            chk(32'(d_out), 32'(j + 100));
        end
        axr(RS, rd, rr);
        chk(rd & 32'h30, 32'h10);
        $display("buffer test done");
        for (int i = 0; i < 5; i++) begin
            pins <= {12'h0, SER[i].div, 2'b00};
            cbusy <= SER[i].ctrl[5];
            axw(RC, 32'(SER[i].ctrl), 2'h0);
            a = 16'hA0A0 ^ 16'(i);
            b = ~a;
            load(a, b);
            wait32();
            chk(word, SER[i].ctrl[2] ? {a, b} : {b, a});
            chk(32'(period) * `ADCPM_CLK_NS, 32'(SER[i].ns));
            chk(32'(d_oe), 32'h0100);
            chk({31'h0, sclk_oe}, 32'h1);
            axr(RS, rd, rr);
            chk(rd & 32'hF, {28'h0, SER[i].eff, 2'b01});
        end
        cbusy <= 1'b1;
        axw(RC, 32'h10, 2'h0);
        load(16'h0F0F, 16'h3C3C);
        repeat (40) @(posedge clk);
        chk(32'(bits), 32'h0);
        cbusy <= 1'b0;
        wait32();
        chk(word, 32'h3C3C0F0F);
        $display("master serial test done");
        for (k = 0; k < 2; k++) begin
            pins <= 16'h0090;
            half <= 8'(2 + k * 3);
            axw(RC, 32'h14, 2'h0);
            load(16'hC3A5, 16'h5A3C);
            repeat (6) @(posedge clk);
            go <= 1'b1;
            wait32();
            go <= 1'b0;
            chk(word, 32'hC3A55A3C);
            chk({31'h0, sclk_oe}, 32'h0);
            axr(RS, rd, rr);
            chk(rd & 32'h3, 32'h3);
        end
        $display("slave serial test done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({d_oe, d_out}, 32'hFFFF0000);
        axr(RC, rd, rr);
        chk(rd, 32'h0);
        $display("second reset test done");
        conclude();
    end
endmodule
